/* inc/dss_defines.svh */
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

// ****************************************
// Register indices (byte address is four times)
// ****************************************
`define DSS_IDX_SCR2 12'h108
`define DSS_IDX_SCR3 12'h109
`define DSS_IDX_EFR 12'h10A
`define DSS_IDX_CTL 12'h100
`define DSS_IDX_CMP 12'h110
`define DSS_IDX_STAT 12'h10B
`define DSS_ADDR_W 14

// ****************************************
// Control register fields
// ****************************************
`define DSS_CTL_ARM 7
`define DSS_CTL_IMMEDIATE_TRIGGER 6
`define DSS_CTL_EXTERNAL_EVENT_ENABLE_LO 0
`define DSS_CTL_EXTERNAL_EVENT_ENABLE_HI 1
`define DSS_EXTERNAL_EVENT_ENABLE_EXT 2'h2

// ****************************************
// Next-state fields and event flag bits
// ****************************************
`define DSS_F0_LO 0
`define DSS_F1_LO 2
`define DSS_F3_LO 6
`define DSS_EF_EXT 4
`define DSS_EF_IMMEDIATE_TRIGGER 6
`define DSS_RESP_OKAY 2'h0
`define DSS_RESP_SLVERR 2'h2

`endif

/* inc/dss_pkg.sv */
package dss_pkg;
  typedef enum logic [2:0] {
    DSS_ST0 = 3'b000,
    DSS_ST1 = 3'b001,
    DSS_ST2 = 3'b010,
    DSS_ST3 = 3'b011,
    DSS_STF = 3'b100
  } dss_state_t;
endpackage : dss_pkg

/* verilog/dss_sequencer.sv */
`timescale 1ns/10ps
`include "dss_defines.svh"
// Functional notes
// - State2: channel 0 field picks next state
// - State2: channel 1 field picks next state
// - State2: channel 3 field, or external event
// - State2 codes: none, State1, State3, Final
// - Highest numbered simultaneous match wins
// - State3: channel 0 field picks next state
// - State3: channel 1 field picks next state
// - State3 codes: none, State1, State2, Final
// - Next-state registers writable only when disarmed
// - Match counts only with comparator enabled
// - Event flags read-only, set by events
// - Non-trigger flags set only while armed
// - Trigger flag set armed or arming write
// - Other flags cleared only by arming
// - Set flag never blocks other flags
// - Bit 6 records trigger event
// - Bit 4 records external event
// - Bits 3-0 record channel matches
// - Arming enters State1; completion returns State0
// - Immediate trigger with arm bit set forces Final; reads zero
// - State codes 000..100, others reserved
module dss_sequencer
  import dss_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] match_in,
  input wire logic external_event_in,
  input wire logic session_done_in,
  input wire logic [1:0] state1_next_code_in,
  input wire logic [`DSS_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [`DSS_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic armed_out,
  output logic [2:0] sequencer_state_code_out
);

  if (CHANNELS != 4) begin : g_chk
    $error("dss_sequencer supports exactly four channels");
  end

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ****************************************
  // Write channel capture
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [`DSS_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid_out;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // Both readies stay low while a response is pending
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_held && !s_axi_bvalid_out
        && !(s_axi_awvalid_in && s_axi_awready_out);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_wready_out <= !w_held && !s_axi_bvalid_out
        && !(s_axi_wvalid_in && s_axi_wready_out);
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  logic [`DSS_ADDR_W-3:0] wr_idx;
  logic wr_lane0;
  logic wr_hit;
  assign wr_idx = aw_addr[`DSS_ADDR_W-1:2];
  assign wr_lane0 = wr_go && w_strb[0];
  assign wr_hit = (wr_idx == `DSS_IDX_SCR2) || (wr_idx == `DSS_IDX_SCR3)
    || (wr_idx == `DSS_IDX_EFR) || (wr_idx == `DSS_IDX_CTL)
    || (wr_idx == `DSS_IDX_CMP) || (wr_idx == `DSS_IDX_STAT);

  logic ctl_wr;
  logic arm_set;
  logic immediate_trigger_req;
  assign ctl_wr = wr_lane0 && (wr_idx == `DSS_IDX_CTL);
  assign arm_set = ctl_wr && w_data[`DSS_CTL_ARM] && !armed_out;
  assign immediate_trigger_req = ctl_wr && w_data[`DSS_CTL_IMMEDIATE_TRIGGER];

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `DSS_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_hit ? `DSS_RESP_OKAY : `DSS_RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] state_two_next_state_ctrl;
  logic [7:0] state_three_next_state_ctrl;
  logic [1:0] external_event_enable;
  logic [3:0] comparator_enable;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_two_next_state_ctrl <= 8'h00;
      state_three_next_state_ctrl <= 8'h00;
      external_event_enable <= 2'h0;
      comparator_enable <= 4'h0;
    end else if (wr_lane0 && !armed_out) begin
      if (wr_idx == `DSS_IDX_SCR2) begin
        state_two_next_state_ctrl <= w_data[7:0] & 8'hCF;
      end
      if (wr_idx == `DSS_IDX_SCR3) begin
        state_three_next_state_ctrl <= w_data[7:0] & 8'hCF;
      end
      if (wr_idx == `DSS_IDX_CTL) begin
        external_event_enable <= w_data[`DSS_CTL_EXTERNAL_EVENT_ENABLE_HI:`DSS_CTL_EXTERNAL_EVENT_ENABLE_LO];
      end
      if (wr_idx == `DSS_IDX_CMP) begin
        comparator_enable <= w_data[3:0];
      end
    end
  end

  // ****************************************
  // Qualified events
  // ****************************************
  logic ext_mode;
  logic [3:0] chan_hit;
  assign ext_mode = (external_event_enable == `DSS_EXTERNAL_EVENT_ENABLE_EXT);
  genvar ch;
  for (ch = 0; ch < 4; ch++) begin : g_chan
    if (ch == 3) begin : g_c3
      assign chan_hit[ch] = ext_mode ? external_event_in
        : (match_in[ch] && comparator_enable[ch]);
    end else begin : g_cn
      assign chan_hit[ch] = match_in[ch] && comparator_enable[ch];
    end
  end

  // ****************************************
  // State sequencer
  // ****************************************
  dss_state_t seq_state;
  dss_state_t next_seq_state;
  logic [7:0] cur_ctrl;
  logic [1:0] chan_next_state_code;

  always_comb begin
    cur_ctrl = (seq_state == DSS_ST3) ? state_three_next_state_ctrl
      : state_two_next_state_ctrl;
    chan_next_state_code = 2'b00;
    if (chan_hit[3]) begin
      chan_next_state_code = cur_ctrl[`DSS_F3_LO +: 2];
    end else if (chan_hit[1]) begin
      chan_next_state_code = cur_ctrl[`DSS_F1_LO +: 2];
    end else if (chan_hit[0]) begin
      chan_next_state_code = cur_ctrl[`DSS_F0_LO +: 2];
    end
    next_seq_state = seq_state;
    case (chan_next_state_code)
      2'b01: next_seq_state = DSS_ST1;
      2'b10: next_seq_state = (seq_state == DSS_ST3) ? DSS_ST2 : DSS_ST3;
      2'b11: next_seq_state = DSS_STF;
      default: next_seq_state = seq_state;
    endcase
    // State1 exits are decided by the outer State1 logic
    if (seq_state == DSS_ST1) begin
      case (state1_next_code_in)
        2'b01: next_seq_state = DSS_ST2;
        2'b10: next_seq_state = DSS_ST3;
        2'b11: next_seq_state = DSS_STF;
        default: next_seq_state = DSS_ST1;
      endcase
    end
  end

  // Arm control; while armed, a hardware session end beats any register write
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      armed_out <= 1'b0;
    end else if (armed_out && session_done_in) begin
      armed_out <= 1'b0;
    end else if (ctl_wr && !w_data[`DSS_CTL_ARM] && armed_out) begin
      armed_out <= 1'b0;
    end else if (arm_set) begin
      armed_out <= 1'b1;
    end
  end

  // Software disarm keeps the last state for inspection
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      seq_state <= DSS_ST0;
    end else if (armed_out && session_done_in) begin
      seq_state <= DSS_ST0;
    end else if (ctl_wr && !w_data[`DSS_CTL_ARM] && armed_out) begin
      seq_state <= seq_state;
    end else if (arm_set) begin
      seq_state <= w_data[`DSS_CTL_IMMEDIATE_TRIGGER] ? DSS_STF : DSS_ST1;
    end else if (armed_out && immediate_trigger_req) begin
      seq_state <= DSS_STF;
    end else if (armed_out && (seq_state != DSS_ST0) && (seq_state != DSS_STF)) begin
      seq_state <= next_seq_state;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sequencer_state_code_out <= 3'h0;
    end else begin
      sequencer_state_code_out <= seq_state;
    end
  end

  // ****************************************
  // Session event flags
  // ****************************************
  logic [7:0] session_event_flags;
  logic [3:0] match_qual;
  logic [3:0] match_event_flags;
  logic external_event_flag;
  logic trigger_flag;
  assign match_qual = match_in & comparator_enable;

  always_comb begin
    session_event_flags = 8'h00;
    session_event_flags[3:0] = match_event_flags;
    session_event_flags[`DSS_EF_EXT] = external_event_flag;
    session_event_flags[`DSS_EF_IMMEDIATE_TRIGGER] = trigger_flag;
  end

  // Each flag has its own register, so a set flag never masks another
  genvar fb;
  for (fb = 0; fb < CHANNELS; fb++) begin : g_match_flag
    logic flag;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        flag <= 1'b0;
      end else if (arm_set) begin
        flag <= 1'b0;
      end else if (armed_out && match_qual[fb]) begin
        flag <= 1'b1;
      end
    end
    assign match_event_flags[fb] = flag;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      external_event_flag <= 1'b0;
    end else if (arm_set) begin
      external_event_flag <= 1'b0;
    end else if (armed_out && external_event_in) begin
      external_event_flag <= 1'b1;
    end
  end

  // Set wins over the clear of an arming write that also triggers
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      trigger_flag <= 1'b0;
    end else if (immediate_trigger_req && (armed_out || arm_set)) begin
      trigger_flag <= 1'b1;
    end else if (arm_set) begin
      trigger_flag <= 1'b0;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic [`DSS_ADDR_W-3:0] rd_idx;
  logic [31:0] next_rdata;
  logic next_rhit;
  assign rd_idx = s_axi_araddr_in[`DSS_ADDR_W-1:2];

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rhit = 1'b1;
    case (rd_idx)
      `DSS_IDX_SCR2: next_rdata[7:0] = state_two_next_state_ctrl;
      `DSS_IDX_SCR3: next_rdata[7:0] = state_three_next_state_ctrl;
      `DSS_IDX_EFR: next_rdata[7:0] = session_event_flags;
      `DSS_IDX_CTL: next_rdata[7:0] = {armed_out, 5'h00, external_event_enable};
      `DSS_IDX_CMP: next_rdata[3:0] = comparator_enable;
      `DSS_IDX_STAT: next_rdata[2:0] = seq_state;
      default: next_rhit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `DSS_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= next_rdata;
      s_axi_rresp_out <= next_rhit ? `DSS_RESP_OKAY : `DSS_RESP_SLVERR;
    end else if (s_axi_rvalid_out) begin
      if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end else begin
      s_axi_arready_out <= 1'b1;
    end
  end

endmodule : dss_sequencer

/* tb/dss_event_source.sv */
`timescale 1ns/10ps
module dss_event_source (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic fire_in,
  input wire logic [4:0] evt_in,
  output logic [3:0] match_out,
  output logic ext_out
);
  // Events last one cycle, then drop back to idle low
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {ext_out, match_out} <= 5'h00;
    end else begin
      {ext_out, match_out} <= fire_in ? evt_in : 5'h00;
    end
  end
endmodule : dss_event_source

/* tb/dss_monitor.sv */
`timescale 1ns/10ps
module dss_monitor (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic session_done_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic armed_out,
  input wire logic [2:0] sequencer_state_code_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered");
  a_write_busy: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  a_read_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while data pending");
  a_upper_zero: assert property (
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000) else $error("upper bits set");
  a_state_legal: assert property (sequencer_state_code_out <= 3'h4)
    else $error("reserved state code");
  a_done_idle: assert property (session_done_in |-> ##[1:3]
    (!armed_out && sequencer_state_code_out == 3'h0)) else $error("session end not idle");
  a_disarm_frozen: assert property (
    (!armed_out && !session_done_in) [*3] |-> $stable(sequencer_state_code_out))
    else $error("state moved while disarmed");
  a_arm_enters: assert property ($rose(armed_out) |-> ##[1:2]
    sequencer_state_code_out inside {3'h1, 3'h4}) else $error("arming missed state1");
endmodule : dss_monitor

/* tb/debug_state_sequencer_events_bench.sv */
`timescale 1ns/10ps
`include "dss_defines.svh"
module debug_state_sequencer_events_bench;
  logic clk = 1'h0, rst_n = 1'h0, done = 1'h0, fire = 1'h0;
  logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic awr, wrdy, bv, arr, rv, armed, ext;
  logic [1:0] bresp, rresp, rs, bs;
  logic [1:0] s1n = 2'h0;
  logic [2:0] st;
  logic [3:0] match;
  logic [4:0] evt = 5'h00;
  logic [11:0] a;
  logic [13:0] awa = 14'h0000, ara = 14'h0000;
  logic [31:0] wd = 32'h0, rdata, rd;
  int n_errors = 0;
  int total_checks = 0;
  typedef struct packed {logic [3:0] en; logic [4:0] ev; logic [7:0] efr;} dss_row_t;
  dss_row_t rows [5] = '{'{4'hF, 5'h0A, 8'h0A}, '{4'h0, 5'h1F, 8'h10},
    '{4'hF, 5'h1F, 8'h1F}, '{4'h3, 5'h0C, 8'h00}, '{4'hF, 5'h01, 8'h01}};

  dss_event_source i_src (.core_clk_in(clk), .reset_n_in(rst_n), .fire_in(fire),
    .evt_in(evt), .match_out(match), .ext_out(ext));
  dss_sequencer i_dut (.core_clk_in(clk), .reset_n_in(rst_n), .match_in(match),
    .external_event_in(ext), .session_done_in(done), .state1_next_code_in(s1n),
    .s_axi_awaddr_in(awa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rry), .armed_out(armed), .sequencer_state_code_out(st));

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    awa <= {idx, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
      if (bv) begin
        bry <= 1'h0;
        bs = bresp;
        break;
      end
    end
    @(posedge clk);
  endtask : wr

  task automatic rd_reg(input logic [11:0] idx);
    ara <= {idx, 2'h0};
    arv <= 1'h1;
    rry <= 1'h1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      if (rv) begin
        rry <= 1'h0;
        rd = rdata;
        rs = rresp;
        break;
      end
    end
    @(posedge clk);
  endtask : rd_reg

  task automatic pulse(input logic [4:0] e);
    evt <= e;
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
    repeat (2) @(posedge clk);
  endtask : pulse

  task automatic walk(input logic [7:0] s2, input logic [7:0] s3, input logic [1:0] ee,
    input logic [1:0] go, input logic [4:0] ev, input logic [2:0] exp);
    wr(`DSS_IDX_CTL, 8'h00);
    wr(`DSS_IDX_SCR2, s2);
    wr(`DSS_IDX_SCR3, s3);
    wr(`DSS_IDX_CTL, {6'h20, ee});
    s1n <= go;
    @(posedge clk);
    s1n <= 2'h0;
    pulse(ev);
    @(posedge clk);
    chk({29'h0, st}, {29'h0, exp});
  endtask : walk

  initial begin
    forever #5 clk = ~clk;
  end

  initial begin
    #100us;
    n_errors++;
    conclude();
  end

  // ****************************************
  // Flag table, then register and session cases
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk({29'h0, st}, 32'h0);
    foreach (rows[i]) begin
      wr(`DSS_IDX_CTL, 8'h00);
      wr(`DSS_IDX_CMP, {4'h0, rows[i].en});
      wr(`DSS_IDX_CTL, 8'h80);
      chk({29'h0, st}, 32'h1);
      pulse(rows[i].ev);
      rd_reg(`DSS_IDX_EFR);
      chk(rd, {24'h0, rows[i].efr});
    end
    wr(`DSS_IDX_CTL, 8'h00);
    pulse(5'h1E);
    rd_reg(`DSS_IDX_EFR);
    chk(rd, 32'h01);
    for (a = `DSS_IDX_SCR2; a <= `DSS_IDX_SCR3; a++) begin
      wr(`DSS_IDX_CTL, 8'h00);
      wr(a, 8'hFF);
      rd_reg(a);
      chk(rd, 32'hCF);
      wr(`DSS_IDX_CTL, 8'h80);
      wr(a, 8'h00);
      rd_reg(a);
      chk(rd, 32'hCF);
    end
    wr(`DSS_IDX_EFR, 8'hFF);
    rd_reg(`DSS_IDX_EFR);
    chk(rd, 32'h00);
    chk({30'h0, bs}, {30'h0, `DSS_RESP_OKAY});
    chk({30'h0, rs}, {30'h0, `DSS_RESP_OKAY});
    pulse(5'h02);
    wr(`DSS_IDX_CTL, 8'hC0);
    rd_reg(`DSS_IDX_EFR);
    chk(rd, 32'h42);
    chk({29'h0, st}, 32'h4);
    rd_reg(`DSS_IDX_CTL);
    chk(rd, 32'h80);
    wr(`DSS_IDX_CTL, 8'h00);
    wr(`DSS_IDX_CTL, 8'hC0);
    rd_reg(`DSS_IDX_EFR);
    chk(rd, 32'h40);
    rd_reg(12'h1FF);
    chk({30'h0, rs}, {30'h0, `DSS_RESP_SLVERR});
    wr(12'h1FF, 8'h00);
    chk({30'h0, bs}, {30'h0, `DSS_RESP_SLVERR});
    done <= 1'h1;
    @(posedge clk);
    done <= 1'h0;
    repeat (3) @(posedge clk);
    chk({28'h0, armed, st}, 32'h0);
    walk(8'h01, 8'h00, 2'h0, 2'h1, 5'h01, 3'h1);
    walk(8'h08, 8'h00, 2'h0, 2'h1, 5'h02, 3'h3);
    walk(8'hC1, 8'h00, 2'h0, 2'h1, 5'h09, 3'h4);
    walk(8'hC0, 8'h00, 2'h2, 2'h1, 5'h08, 3'h2);
    walk(8'hC0, 8'h00, 2'h2, 2'h1, 5'h10, 3'h4);
    walk(8'h00, 8'h00, 2'h0, 2'h1, 5'h0F, 3'h2);
    walk(8'h00, 8'h01, 2'h0, 2'h2, 5'h01, 3'h1);
    walk(8'h00, 8'h08, 2'h0, 2'h2, 5'h02, 3'h2);
    walk(8'h00, 8'h4C, 2'h0, 2'h2, 5'h0A, 3'h1);
    walk(8'h00, 8'hC0, 2'h2, 2'h2, 5'h10, 3'h4);
    conclude();
  end
endmodule : debug_state_sequencer_events_bench

bind dss_sequencer dss_monitor i_mon (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .session_done_in(session_done_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rdata_out(s_axi_rdata_out),
  .armed_out(armed_out), .sequencer_state_code_out(sequencer_state_code_out));
